// File: logic/pllc_pkg.sv
// package: constants and types for the pll control block
package pllc_pkg;

	// ----------------------------------------
	// reset values and widths
	// ----------------------------------------
	localparam int RANGE_W = 4;
	localparam logic [3:0] RANGE_RESET = 4'h6;
	localparam logic [3:0] RANGE_OFF = 4'h0;
	localparam logic PLL_ON_RESET = 1'b1;
	localparam logic SELECT_RESET = 1'b0;
	localparam int SWITCH_CYCLES = 3;
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------
	// grouped signals
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic irq_enable;
		logic pll_power_on;
		logic base_clock_select;
	} pllc_ctrl_wr_t;

	typedef struct packed {
		logic wr;
		logic [3:0] vco_range_select;
	} pllc_range_wr_t;

	typedef struct packed {
		logic lock_change_flag;
		logic lock_change_irq_enable;
		logic pll_power_on;
		logic base_clock_select;
	} pllc_ctrl_rd_t;

endpackage : pllc_pkg

// File: logic/pllc_sync.sv
// three-stage synchroniser for asynchronous status inputs
`timescale 1ns/1ps
module pllc_sync
	import pllc_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic async_in,
	output logic level_out
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic level_q;
	logic level_d;

	always_comb begin
		stage_d = {stage_q[1:0], async_in};
		// change accepted once the second and third stage agree
		level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stage_q <= {3{RESET_VAL}};
			level_q <= RESET_VAL;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign level_out = level_q;
endmodule : pllc_sync

// File: logic/pllc_switch.sv
// base clock switch-over hold timer
`timescale 1ns/1ps
module pllc_switch
	import pllc_pkg::*;
#(
	parameter int HOLD = SWITCH_CYCLES
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic select_in,
	output logic select_out,
	output logic busy_out
);
	// the hold counter is four bits wide
	if (HOLD < 1 || HOLD > 15) begin : g_bad_hold
		$error("pllc_switch: HOLD out of range");
	end

	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic sel_q;
	logic sel_d;

	always_comb begin
		cnt_d = cnt_q;
		sel_d = sel_q;
		if (cnt_q != 4'h0) begin
			cnt_d = cnt_q - 4'h1;
			if (cnt_q == 4'h1) sel_d = select_in;
		end else if (select_in != sel_q) begin
			cnt_d = 4'(HOLD);
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= 4'h0;
			sel_q <= SELECT_RESET;
		end else begin
			cnt_q <= cnt_d;
			sel_q <= sel_d;
		end
	end

	assign select_out = sel_q;
	assign busy_out = (cnt_q != 4'h0);
endmodule : pllc_switch

// File: logic/pllc_top.sv
// pll control, lock-change flag and low-power gating
`timescale 1ns/1ps
module pllc_top
	import pllc_pkg::*;
#(
	parameter int HOLD = SWITCH_CYCLES
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire pllc_ctrl_wr_t ctrl_in,
	input wire pllc_range_wr_t range_in,
	input wire logic auto_mode_in,
	input wire logic acq_done_in,
	input wire logic lock_detect_in,
	input wire logic stop_mode_in,
	input wire logic wait_mode_in,
	input wire logic break_state_in,
	input wire logic break_clear_enable_in,
	input wire logic xtal_div_in,
	input wire logic vco_div_in,
	output pllc_ctrl_rd_t ctrl_out,
	output logic [3:0] vco_range_select_out,
	output logic lock_out,
	output logic acquisition_mode_bit_out,
	output logic pll_enable_out,
	output logic osc_enable_out,
	output logic base_clock_out,
	output logic clock_gen_interrupt_out
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic lock_s;
	logic acq_s;
	logic xtal_s;
	logic vco_s;

	// lock and acquisition come from the analog loop, not from this clock
	pllc_sync u_sync_lock (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.async_in(lock_detect_in),
		.level_out(lock_s)
	);

	pllc_sync u_sync_acq (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.async_in(acq_done_in),
		.level_out(acq_s)
	);

	// halved source clocks are only sampled, so the output is a coarse copy
	pllc_sync u_sync_xtal (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.async_in(xtal_div_in),
		.level_out(xtal_s)
	);

	pllc_sync u_sync_vco (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.async_in(vco_div_in),
		.level_out(vco_s)
	);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// the switch counter is four bits wide
	if (HOLD < 1 || HOLD > 15) begin : g_bad_hold
		$error("pllc_top: HOLD out of range");
	end

	// ----------------------------------------
	// control register state
	// ----------------------------------------
	logic [3:0] range_q;
	logic [3:0] range_d;
	logic on_q;
	logic on_d;
	logic sel_q;
	logic sel_d;
	logic ie_q;
	logic ie_d;
	logic flag_q;
	logic flag_d;
	logic lock_q;
	logic lock_d;
	logic acq_q;
	logic acq_d;
	logic lock_prev_q;
	logic lock_prev_d;
	logic on_w;
	logic sel_w;
	logic protect;
	logic lock_edge;

	// ----------------------------------------
	// access qualifiers
	// ----------------------------------------
	always_comb begin
		protect = break_state_in && !break_clear_enable_in;
		// only counted with the automatic loop running
		lock_edge = auto_mode_in && (lock_s != lock_prev_q);
	end

	// ----------------------------------------
	// range select
	// ----------------------------------------
	always_comb begin
		range_d = range_q;
		// never retuned while the loop runs
		if (range_in.wr && !on_q) range_d = range_in.vco_range_select;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			range_q <= RANGE_RESET;
		end else begin
			range_q <= range_d;
		end
	end

	// ----------------------------------------
	// power, select and interrupt enable
	// ----------------------------------------
	always_comb begin
		on_d = on_q;
		sel_d = sel_q;
		ie_d = ie_q;
		on_w = ctrl_in.pll_power_on;
		sel_w = ctrl_in.base_clock_select;
		// wait mode has no effect here on purpose
		if (ctrl_in.wr) begin
			ie_d = auto_mode_in ? ctrl_in.irq_enable : ie_q;
			if (sel_q) on_w = 1'b1;
			if (!on_q || range_q == RANGE_OFF) sel_w = 1'b0;
			// lock state is not checked on select
			sel_d = sel_w;
			on_d = on_w;
		end
		if (range_q == RANGE_OFF) begin
			sel_d = 1'b0;
		end
		if (!auto_mode_in) begin
			ie_d = 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			on_q <= PLL_ON_RESET;
			sel_q <= SELECT_RESET;
			ie_q <= 1'b0;
		end else begin
			on_q <= on_d;
			sel_q <= sel_d;
			ie_q <= ie_d;
		end
	end

	// ----------------------------------------
	// lock-change flag
	// ----------------------------------------
	always_comb begin
		flag_d = flag_q;
		// read clears unless break protects it; a protected read is dropped, not replayed after break
		if (ctrl_in.rd && !protect) flag_d = 1'b0;
		// set beats clear in the same cycle
		if (lock_edge) flag_d = 1'b1;
		if (!auto_mode_in) flag_d = 1'b0;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	// ----------------------------------------
	// lock and acquisition status
	// ----------------------------------------
	always_comb begin
		lock_prev_d = lock_s;
		lock_d = auto_mode_in && lock_s;
		acq_d = auto_mode_in && acq_s;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lock_q <= 1'b0;
			acq_q <= 1'b0;
			lock_prev_q <= 1'b0;
		end else begin
			lock_q <= lock_d;
			acq_q <= acq_d;
			lock_prev_q <= lock_prev_d;
		end
	end

	// ----------------------------------------
	// clock switch and output stage
	// ----------------------------------------
	logic sel_eff;
	logic sw_busy;

	pllc_switch #(.HOLD(HOLD)) u_switch (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.select_in(sel_q),
		.select_out(sel_eff),
		.busy_out(sw_busy)
	);

	logic clk_q;
	logic clk_d;
	logic pll_en_q;
	logic pll_en_d;
	logic osc_en_q;
	logic osc_en_d;
	logic irq_q;
	logic irq_d;
	pllc_ctrl_rd_t rd_q;
	pllc_ctrl_rd_t rd_d;

	// ----------------------------------------
	// base clock output
	// ----------------------------------------
	always_comb begin
		clk_d = clk_q;
		// held while the switch settles so no runt pulse escapes
		if (!sw_busy) clk_d = sel_eff ? vco_s : xtal_s;
		if (stop_mode_in) clk_d = 1'b0;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_q <= 1'b0;
		end else begin
			clk_q <= clk_d;
		end
	end

	// ----------------------------------------
	// oscillator and loop enables
	// ----------------------------------------
	always_comb begin
		pll_en_d = on_q && (range_q != RANGE_OFF) && !stop_mode_in;
		osc_en_d = !stop_mode_in;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pll_en_q <= 1'b0;
			osc_en_q <= 1'b0;
		end else begin
			pll_en_q <= pll_en_d;
			osc_en_q <= osc_en_d;
		end
	end

	// ----------------------------------------
	// interrupt and read-back
	// ----------------------------------------
	always_comb begin
		irq_d = flag_q && ie_q && auto_mode_in;
		// gated like the request so both agree in the cycle manual mode starts
		rd_d.lock_change_flag = flag_q && auto_mode_in;
		rd_d.lock_change_irq_enable = ie_q && auto_mode_in;
		rd_d.pll_power_on = on_q;
		rd_d.base_clock_select = sel_q;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_q <= 1'b0;
			rd_q <= '0;
		end else begin
			irq_q <= irq_d;
			rd_q <= rd_d;
		end
	end

	assign ctrl_out = rd_q;
	assign vco_range_select_out = range_q;
	assign lock_out = lock_q;
	assign acquisition_mode_bit_out = acq_q;
	assign pll_enable_out = pll_en_q;
	assign osc_enable_out = osc_en_q;
	assign base_clock_out = clk_q;
	assign clock_gen_interrupt_out = irq_q;
endmodule : pllc_top

// File: bench/pllc_assertions.sv
// checker: port-level properties of the pll control block
`timescale 1ns/1ps
module pllc_assertions
	import pllc_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire pllc_ctrl_wr_t ctrl_in,
	input wire pllc_range_wr_t range_in,
	input wire logic auto_mode_in,
	input wire logic stop_mode_in,
	input wire logic break_state_in,
	input wire logic break_clear_enable_in,
	input wire pllc_ctrl_rd_t ctrl_out,
	input wire logic [3:0] vco_range_select_out,
	input wire logic lock_out,
	input wire logic pll_enable_out,
	input wire logic osc_enable_out,
	input wire logic base_clock_out,
	input wire logic clock_gen_interrupt_out
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// ctrl_out lags the state by one edge, so two samples pin the state
	a_range_write_locked: assert property (range_in.wr && ctrl_out.pll_power_on ##1 ctrl_out.pll_power_on
		|-> $stable(vco_range_select_out)) else $error("range moved");
	a_range_zero_off: assert property ((vco_range_select_out == 4'h0)[*3]
		|-> !pll_enable_out && !ctrl_out.base_clock_select) else $error("range zero");
	a_reset_range: assert property ($rose(rst_n_in) |-> vco_range_select_out == RANGE_RESET) else $error("reset range");
	a_lock_sets_flag: assert property (auto_mode_in[*4] ##0 $changed(lock_out)
		|-> ##[0:3] ctrl_out.lock_change_flag) else $error("flag missed");
	a_irq_level: assert property (clock_gen_interrupt_out ==
		(ctrl_out.lock_change_flag && ctrl_out.lock_change_irq_enable)) else $error("irq level");
	a_manual_quiet: assert property ((!auto_mode_in)[*4]
		|-> !ctrl_out.lock_change_flag && !lock_out && !clock_gen_interrupt_out) else $error("manual");
	a_stop_low: assert property (stop_mode_in[*2]
		|-> !osc_enable_out && !pll_enable_out && !base_clock_out) else $error("stop");
	a_flag_clear_cause: assert property ($fell(ctrl_out.lock_change_flag) && auto_mode_in
		|-> $past(ctrl_in.rd, 2) && !($past(break_state_in, 2) && !$past(break_clear_enable_in, 2)))
		else $error("flag cleared");
	a_select_guard: assert property (ctrl_out.base_clock_select
		|-> ctrl_out.pll_power_on && vco_range_select_out != 4'h0) else $error("select guard");
	c_irq: cover property (clock_gen_interrupt_out);
	c_select: cover property (ctrl_out.base_clock_select);
	c_break_hold: cover property (break_state_in && ctrl_out.lock_change_flag);
endmodule : pllc_assertions

// File: bench/pllc_top_test.sv
// testbench: directed port sequences for the pll control block
`timescale 1ns/1ps
module pllc_top_test
	import pllc_pkg::*;
;
	logic mclk_in = 0;
	logic rst_n_in = 0;
	pllc_ctrl_wr_t ctrl_in = '0;
	pllc_range_wr_t range_in = '0;
	logic auto_mode_in = 0, acq_done_in = 0, lock_detect_in = 0, stop_mode_in = 0, wait_mode_in = 0;
	logic break_state_in = 0, break_clear_enable_in = 0, xtal_div_in = 0, vco_div_in = 0;
	pllc_ctrl_rd_t ctrl_out;
	logic [3:0] vco_range_select_out;
	logic lock_out, acquisition_mode_bit_out, pll_enable_out, osc_enable_out, base_clock_out;
	logic clock_gen_interrupt_out;
	int error_cnt = 0;
	int total_checks = 0;
	always #2.5 mclk_in = ~mclk_in;
	pllc_top #(.HOLD(3)) u_dut (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.ctrl_in(ctrl_in),
		.range_in(range_in),
		.auto_mode_in(auto_mode_in),
		.acq_done_in(acq_done_in),
		.lock_detect_in(lock_detect_in),
		.stop_mode_in(stop_mode_in),
		.wait_mode_in(wait_mode_in),
		.break_state_in(break_state_in),
		.break_clear_enable_in(break_clear_enable_in),
		.xtal_div_in(xtal_div_in),
		.vco_div_in(vco_div_in),
		.ctrl_out(ctrl_out),
		.vco_range_select_out(vco_range_select_out),
		.lock_out(lock_out),
		.acquisition_mode_bit_out(acquisition_mode_bit_out),
		.pll_enable_out(pll_enable_out),
		.osc_enable_out(osc_enable_out),
		.base_clock_out(base_clock_out),
		.clock_gen_interrupt_out(clock_gen_interrupt_out)
	);
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic p(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : p
	task automatic wctl(input logic [2:0] v);
		@(negedge mclk_in);
		ctrl_in = {2'b10, v};
		@(negedge mclk_in);
		ctrl_in = '0;
	endtask : wctl
	task automatic rdc();
		@(negedge mclk_in);
		ctrl_in = 5'b01000;
		@(negedge mclk_in);
		ctrl_in = '0;
	endtask : rdc
	task automatic wrange(input logic [3:0] v);
		@(negedge mclk_in);
		range_in = {1'b1, v};
		@(negedge mclk_in);
		range_in = '0;
	endtask : wrange
	task automatic chk(input logic [3:0] g, input logic [3:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic tend(input int n);
		$display("test %0d done", n);
	endtask : tend
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// sequences
	// ----------------------------------------
	initial begin
		p(5);
		rst_n_in = 1;
		chk(vco_range_select_out, 4'h6);
		wrange(4'h3);
		p(2);
		chk(ctrl_out, 4'h2);
		chk(vco_range_select_out, 4'h6);
		tend(1);
		wctl(3'b011);
		p(2);
		chk(ctrl_out, 4'h3);
		wctl(3'b000);
		p(2);
		chk(ctrl_out, 4'h2);
		wctl(3'b000);
		wctl(3'b001);
		p(2);
		chk(ctrl_out, 4'h0);
		wrange(4'h0);
		wctl(3'b010);
		wctl(3'b011);
		p(3);
		chk({2'b00, pll_enable_out, ctrl_out.base_clock_select}, 4'h0);
		wctl(3'b000);
		wrange(4'h6);
		wctl(3'b010);
		tend(2);
		// lock changes only count with the automatic loop running
		auto_mode_in = 1;
		wctl(3'b110);
		lock_detect_in = 1;
		p(8);
		chk({1'b0, ctrl_out.lock_change_flag, clock_gen_interrupt_out, lock_out}, 4'h7);
		rdc();
		p(3);
		chk({2'b00, ctrl_out.lock_change_flag, clock_gen_interrupt_out}, 4'h0);
		wctl(3'b010);
		lock_detect_in = 0;
		p(8);
		chk({1'b0, ctrl_out.lock_change_flag, clock_gen_interrupt_out, lock_out}, 4'h4);
		break_state_in = 1;
		rdc();
		p(3);
		chk({3'b000, ctrl_out.lock_change_flag}, 4'h1);
		break_clear_enable_in = 1;
		rdc();
		p(3);
		break_state_in = 0;
		break_clear_enable_in = 0;
		p(2);
		chk({3'b000, ctrl_out.lock_change_flag}, 4'h0);
		tend(3);
		acq_done_in = 1;
		lock_detect_in = 1;
		xtal_div_in = 1;
		p(8);
		chk({2'b00, acquisition_mode_bit_out, lock_out}, 4'h3);
		wctl(3'b011);
		p(2);
		chk({3'b000, base_clock_out}, 4'h1);
		p(3);
		chk({3'b000, base_clock_out}, 4'h0);
		vco_div_in = 1;
		p(6);
		chk({3'b000, base_clock_out}, 4'h1);
		auto_mode_in = 0;
		wctl(3'b111);
		p(4);
		chk({ctrl_out.lock_change_flag, ctrl_out.lock_change_irq_enable, clock_gen_interrupt_out, lock_out}, 4'h0);
		wait_mode_in = 1;
		p(4);
		chk({1'b0, pll_enable_out, osc_enable_out, ctrl_out.base_clock_select}, 4'h7);
		wait_mode_in = 0;
		stop_mode_in = 1;
		p(3);
		chk({1'b0, osc_enable_out, pll_enable_out, base_clock_out}, 4'h0);
		stop_mode_in = 0;
		wctl(3'b000);
		wctl(3'b000);
		p(2);
		chk({1'b0, pll_enable_out, ctrl_out.pll_power_on, ctrl_out.base_clock_select}, 4'h0);
		tend(4);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge mclk_in);
		error_cnt++;
		close_out();
	end
endmodule : pllc_top_test
bind pllc_top pllc_assertions u_chk (
	.mclk_in(mclk_in),
	.rst_n_in(rst_n_in),
	.ctrl_in(ctrl_in),
	.range_in(range_in),
	.auto_mode_in(auto_mode_in),
	.stop_mode_in(stop_mode_in),
	.break_state_in(break_state_in),
	.break_clear_enable_in(break_clear_enable_in),
	.ctrl_out(ctrl_out),
	.vco_range_select_out(vco_range_select_out),
	.lock_out(lock_out),
	.pll_enable_out(pll_enable_out),
	.osc_enable_out(osc_enable_out),
	.base_clock_out(base_clock_out),
	.clock_gen_interrupt_out(clock_gen_interrupt_out)
);
